// >>> include/mccs_regs.svh
// Register offsets, fields, reset values and timing counts of the clock switch
`ifndef MCCS_REGS_SVH
`define MCCS_REGS_SVH

`define MCCS_ADDR_W 5
`define MCCS_OFS_CTRL 5'h00
`define MCCS_OFS_RATE 5'h04
`define MCCS_OFS_DIV 5'h08
`define MCCS_OFS_CMD 5'h0c
`define MCCS_OFS_STAT 5'h10

`define MCCS_CTRL_W 5
`define MCCS_CTRL_RST 5'h00
`define MCCS_RATE_W 4
`define MCCS_RATE_RST 4'h2
`define MCCS_RATE_MAX 4'ha
`define MCCS_DIV_W 10
`define MCCS_DIV_RST 10'h001
`define MCCS_DIV_MAX 10'h3fe
`define MCCS_CMD_LOAD_BIT 0
`define MCCS_STAT_DIVERR_BIT 4
`define MCCS_STAT_RATEERR_BIT 6

// System clock in MHz; internal half period is CLK_MHZ / (2 * rate MHz)
`define MCCS_CLK_MHZ 20
`define MCCS_HALF_W 4

`endif

// >>> include/mccs_pkg.sv
// Types shared by the configuration clock switch
package mccs_pkg;

  typedef struct packed {
    logic user_pin_level;
    logic user_pin_use;
    logic end_of_startup;
    logic config_done;
    logic ext_clock_select_enable;
  } mccs_ctrl_t;

  typedef enum logic [2:0] {
    MCCS_SRC_INT = 3'b001,
    MCCS_SRC_PARK = 3'b010,
    MCCS_SRC_EXT = 3'b100
  } mccs_src_t;

  typedef struct packed {
    logic out;
    logic oe;
  } mccs_pin_t;

endpackage : mccs_pkg

// >>> hw/mccs_ext_div.sv
// Divider of the synchronised external configuration clock
`timescale 1ns/1ps
`include "mccs_regs.svh"

module mccs_ext_div (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ext_sync,
  input wire logic [`MCCS_DIV_W-1:0] divide,
  output logic level,
  output logic rise
);

  logic ext_prev;
  logic [`MCCS_DIV_W-1:0] edge_cnt;
  logic [`MCCS_DIV_W-1:0] half_m1;
  logic [`MCCS_DIV_W-1:0] divide_q;

  assign half_m1 = (divide >> 1) - `MCCS_DIV_W'(1);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ext_prev <= 1'b0;
      divide_q <= `MCCS_DIV_RST;
    end else begin
      ext_prev <= ext_sync;
      divide_q <= divide;
    end
  end

  // Divide by one follows the input; even N toggles every N/2 rising edges
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      level <= 1'b0;
      rise <= 1'b0;
      edge_cnt <= `MCCS_DIV_W'(0);
    end else if (divide == `MCCS_DIV_RST) begin
      level <= ext_sync;
      rise <= ext_sync & ~level;
      edge_cnt <= `MCCS_DIV_W'(0);
    end else if (divide != divide_q) begin
      // New divide value restarts the count so it never overshoots
      edge_cnt <= `MCCS_DIV_W'(0);
      rise <= 1'b0;
    end else if (ext_sync && !ext_prev) begin
      if (edge_cnt >= half_m1) begin
        edge_cnt <= `MCCS_DIV_W'(0);
        level <= ~level;
        rise <= ~level;
      end else begin
        edge_cnt <= edge_cnt + `MCCS_DIV_W'(1);
        rise <= 1'b0;
      end
    end else begin
      rise <= 1'b0;
    end
  end

  AST_DIV_COUNT_BOUND: assert property (@(posedge clk_sys)
    disable iff (!rstn)
    (divide != `MCCS_DIV_RST && $stable(divide)) |-> edge_cnt <= half_m1)
    else $error("edge counter passed half of divide value");

endmodule : mccs_ext_div

// >>> hw/mccs_clock_switch.sv
// Master configuration clock source switch with Avalon-MM registers
`timescale 1ns/1ps
`include "mccs_regs.svh"

// Function
// - Without external enable, configuration never leaves the internal oscillator.
// - Switch to external clock only if external enable set; else ignore it.
// - Divide value is 1 or an even value from 2 to 1022.
// - Configuration always starts on the internal oscillator.
// - Loading the clock setting moves the source to the external input.
// - Source change produces no glitch or runt pulse on the clock.
// - After configuration the external pin serves as a global clock input.
// - At end of startup the input takes the user standard; glitch accepted.
// - After configuration the clock pin is released unless the user uses it.
// - Internal clock follows the rate setting; default 2 gives 2 MHz.
module mccs_clock_switch (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [`MCCS_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic ext_config_clock_in,
  output mccs_pkg::mccs_pin_t config_clock_pin,
  output logic global_clock_input_zero,
  output logic user_io_standard
);
  import mccs_pkg::*;
  default clocking cb_sys @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  function automatic logic div_legal(input logic [`MCCS_DIV_W-1:0] d);
    div_legal = (d == `MCCS_DIV_RST) ||
      (!d[0] && d >= `MCCS_DIV_W'(2) && d <= `MCCS_DIV_MAX);
  endfunction : div_legal

  function automatic logic [`MCCS_HALF_W-1:0] half_of(
      input logic [`MCCS_RATE_W-1:0] r);
    half_of = `MCCS_HALF_W'((`MCCS_CLK_MHZ / 2) / r);
  endfunction : half_of

  mccs_ctrl_t ctrl;
  mccs_src_t state;
  logic [`MCCS_RATE_W-1:0] internal_clock_rate_setting;
  logic [`MCCS_DIV_W-1:0] ext_clock_divide_setting;
  logic pending;
  logic div_err;
  logic rate_err;
  logic ext_meta;
  logic ext_sync;
  logic cfg_clk;
  logic park_seen_high;
  logic [`MCCS_HALF_W-1:0] int_cnt;
  logic int_tick;
  logic ext_level;
  logic ext_rise;
  logic take;
  logic wr_ctrl;
  logic wr_rate;
  logic wr_div;
  logic wr_cmd;
  logic wr_stat;

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, then the access completes

  assign take = (avs_read | avs_write) & avs_waitrequest;
  assign wr_ctrl = take & avs_write & (avs_address == `MCCS_OFS_CTRL);
  assign wr_rate = take & avs_write & (avs_address == `MCCS_OFS_RATE);
  assign wr_div = take & avs_write & (avs_address == `MCCS_OFS_DIV);
  assign wr_cmd = take & avs_write & (avs_address == `MCCS_OFS_CMD);
  assign wr_stat = take & avs_write & (avs_address == `MCCS_OFS_STAT);

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~take;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (take && avs_read) begin
      case (avs_address)
        `MCCS_OFS_CTRL: avs_readdata <= 32'(ctrl);
        `MCCS_OFS_RATE: avs_readdata <= 32'(internal_clock_rate_setting);
        `MCCS_OFS_DIV: avs_readdata <= 32'(ext_clock_divide_setting);
        `MCCS_OFS_STAT: avs_readdata <= 32'({rate_err, cfg_clk, div_err,
                                             pending, state});
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl <= `MCCS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl <= avs_writedata[`MCCS_CTRL_W-1:0];
    end
  end

  // Illegal values are refused and leave a sticky error flag
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ext_clock_divide_setting <= `MCCS_DIV_RST;
      div_err <= 1'b0;
    end else if (wr_div) begin
      if (div_legal(avs_writedata[`MCCS_DIV_W-1:0]) &&
          avs_writedata[31:`MCCS_DIV_W] == '0) begin
        ext_clock_divide_setting <= avs_writedata[`MCCS_DIV_W-1:0];
      end else begin
        div_err <= 1'b1;
      end
    end else if (wr_stat && avs_writedata[`MCCS_STAT_DIVERR_BIT]) begin
      div_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      internal_clock_rate_setting <= `MCCS_RATE_RST;
      rate_err <= 1'b0;
    end else if (wr_rate) begin
      if (avs_writedata[`MCCS_RATE_W-1:0] != '0 &&
          avs_writedata[`MCCS_RATE_W-1:0] <= `MCCS_RATE_MAX &&
          avs_writedata[31:`MCCS_RATE_W] == '0) begin
        internal_clock_rate_setting <= avs_writedata[`MCCS_RATE_W-1:0];
      end else begin
        rate_err <= 1'b1;
      end
    end else if (wr_stat && avs_writedata[`MCCS_STAT_RATEERR_BIT]) begin
      rate_err <= 1'b0;
    end
  end

  // Load request sets over the hardware clear; ignored without enable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pending <= 1'b0;
    end else if (wr_cmd && avs_writedata[`MCCS_CMD_LOAD_BIT] &&
                 ctrl.ext_clock_select_enable) begin
      pending <= 1'b1;
    end else if (!ctrl.ext_clock_select_enable || state != MCCS_SRC_INT) begin
      pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock sources

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
    end else begin
      ext_meta <= ext_config_clock_in;
      ext_sync <= ext_meta;
    end
  end

  // Internal oscillator as a half-period tick from the system clock
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      int_cnt <= '0;
    end else if (int_tick) begin
      int_cnt <= '0;
    end else begin
      int_cnt <= int_cnt + `MCCS_HALF_W'(1);
    end
  end
  assign int_tick = (int_cnt >= half_of(internal_clock_rate_setting) -
                     `MCCS_HALF_W'(1));

  mccs_ext_div u_ext_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ext_sync(ext_sync),
    .divide(ext_clock_divide_setting),
    .level(ext_level),
    .rise(ext_rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Glitchless source switch: leave internal on a falling tick, park low,
  // resume on a source rising edge after a full low phase; costs latency

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= MCCS_SRC_INT;
      cfg_clk <= 1'b0;
      park_seen_high <= 1'b0;
    end else begin
      case (state)
        MCCS_SRC_INT: begin
          if (int_tick) begin
            cfg_clk <= ~cfg_clk;
            if (cfg_clk && pending && ctrl.ext_clock_select_enable) begin
              state <= MCCS_SRC_PARK;
            end
          end
        end
        MCCS_SRC_PARK: begin
          park_seen_high <= park_seen_high | ext_level;
          if (ext_rise && park_seen_high) begin
            cfg_clk <= 1'b1;
            state <= MCCS_SRC_EXT;
          end
        end
        MCCS_SRC_EXT: begin
          cfg_clk <= ext_level;
        end
        default: begin
          state <= MCCS_SRC_INT;
          cfg_clk <= 1'b0;
          park_seen_high <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pins after configuration

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      config_clock_pin <= '{out: 1'b0, oe: 1'b1};
    end else if (ctrl.config_done) begin
      config_clock_pin.oe <= ctrl.user_pin_use;
      config_clock_pin.out <= ctrl.user_pin_level;
    end else begin
      config_clock_pin.oe <= 1'b1;
      config_clock_pin.out <= cfg_clk;
    end
  end

  // Glitches at the standard change pass through; user logic copes
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      global_clock_input_zero <= 1'b0;
      user_io_standard <= 1'b0;
    end else begin
      global_clock_input_zero <= ctrl.config_done & ext_sync;
      user_io_standard <= ctrl.end_of_startup;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_switch_req;
    state == MCCS_SRC_INT && int_tick && cfg_clk && pending &&
      ctrl.ext_clock_select_enable;
  endsequence
  sequence s_parked;
    state == MCCS_SRC_PARK && !cfg_clk;
  endsequence
  AST_INT_STEADY: assert property (
    (state == MCCS_SRC_INT && !int_tick) |=> $stable(cfg_clk))
    else $error("internal clock changed without a tick");
  AST_NO_SWITCH_DISABLED: assert property (
    (state == MCCS_SRC_INT && !ctrl.ext_clock_select_enable) |=>
      state == MCCS_SRC_INT)
    else $error("source left internal while external disabled");
  AST_DIV_LEGAL: assert property (
    div_legal(ext_clock_divide_setting))
    else $error("illegal divide value held");
  AST_START_INTERNAL: assert property (
    $rose(rstn) |-> state == MCCS_SRC_INT && !cfg_clk)
    else $error("configuration did not start on internal clock");
  AST_SWITCH_PARKS: assert property (
    s_switch_req |=> s_parked)
    else $error("switch request did not park the clock low");
  AST_PARK_TO_EXT: assert property (
    s_parked ##0 (ext_rise && park_seen_high) |=>
      state == MCCS_SRC_EXT && cfg_clk)
    else $error("parked clock did not resume on external edge");
  AST_NO_RUNT_LOW: assert property (
    s_parked ##0 !park_seen_high |=> !cfg_clk)
    else $error("runt low pulse on configuration clock");
  AST_PIN_RELEASE: assert property (
    (ctrl.config_done && !ctrl.user_pin_use) |=> !config_clock_pin.oe)
    else $error("clock pin still driven after configuration");
  AST_GCLK_FOLLOWS: assert property (
    ctrl.config_done |=> global_clock_input_zero == $past(ext_sync))
    else $error("global clock input not following external pin");
  AST_RATE_HALF: assert property (
    (int_tick && $stable(internal_clock_rate_setting)) |->
      int_cnt == half_of(internal_clock_rate_setting) - `MCCS_HALF_W'(1))
    else $error("internal half period differs from rate setting");

endmodule : mccs_clock_switch

// >>> dv/mccs_ext_osc.sv
// Free-running external oscillator on the far side of the clock input
`timescale 1ns/1ps

module mccs_ext_osc (
  input wire logic run,
  input wire logic [15:0] half_ns,
  output logic clk_out
);
  // Edges at 13 ns past a 50 ns grid, away from the system clock edges
  initial begin
    clk_out = 1'b0;
    #13;
    forever begin
      clk_out = run ? ~clk_out : 1'b0;
      #(half_ns);
    end
  end
endmodule : mccs_ext_osc

// >>> dv/mccs_clock_switch_bench.sv
// Self-checking bench of the configuration clock switch
`timescale 1ns/1ps
`include "mccs_regs.svh"

module mccs_clock_switch_bench;
  import mccs_pkg::*;
  logic clk_sys;
  logic rstn;
  logic [`MCCS_ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic ext_clk;
  logic osc_run;
  logic [15:0] osc_half;
  mccs_pin_t cfg_pin;
  logic gclk;
  logic user_io;
  int errors;
  int compares;
  logic [63:0] notes[$];
  logic [63:0] nt;
  int n;
  logic [31:0] d;
  int rates[3] = '{1, 5, 10};

  mccs_clock_switch i_dut (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .ext_config_clock_in(ext_clk),
    .config_clock_pin(cfg_pin), .global_clock_input_zero(gclk),
    .user_io_standard(user_io));
  mccs_ext_osc i_osc (.run(osc_run), .half_ns(osc_half), .clk_out(ext_clk));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: %s got %h", $time, m, got);
    end
  endtask : chk

  task wrap_up;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // Request held until waitrequest is seen low at a rising edge
  task av_req(input logic rd, input logic [4:0] a, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= wd;
    do begin
      @(posedge clk_sys);
      t++;
    end while (avs_waitrequest !== 1'b0 && t < 100);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (t >= 100) begin
      errors++;
      $display("wrong value at %0t: no bus answer", $time);
    end
  endtask : av_req

  task av_rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
    notes.push_back({m, e & m});
    av_req(1'b1, a, 32'h0);
  endtask : av_rd

  // Length of the next complete run of the pin clock or the global clock
  task run_len(input logic sel, output int len);
    logic v;
    int t;
    t = 0;
    len = 0;
    v = sel ? gclk : cfg_pin.out;
    while ((sel ? gclk : cfg_pin.out) === v && t < 6000) begin
      @(posedge clk_sys);
      t++;
    end
    v = sel ? gclk : cfg_pin.out;
    while ((sel ? gclk : cfg_pin.out) === v && len < 6000) begin
      @(posedge clk_sys);
      len++;
    end
  endtask : run_len

  always @(posedge clk_sys) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      nt = notes.pop_front();
      chk(avs_readdata & nt[63:32], nt[31:0], "read data");
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    $display("wrong value at %0t: watchdog expired", $time);
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    osc_run = 1'b1;
    osc_half = 16'd250;
    errors = 0;
    compares = 0;
    n = $urandom(32'h5445);
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    av_rd(`MCCS_OFS_CTRL, 32'h0, 32'hffffffff);
    av_rd(`MCCS_OFS_RATE, 32'(`MCCS_RATE_RST), 32'hf);
    av_rd(`MCCS_OFS_DIV, 32'(`MCCS_DIV_RST), 32'h3ff);
    av_rd(`MCCS_OFS_STAT, 32'h1, 32'h7);
    av_rd(5'h14, 32'h0, 32'hffffffff);
    chk({31'h0, cfg_pin.oe}, 32'h1, "pin drive in config");
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      av_req(1'b0, `MCCS_OFS_RATE, 32'(rates[i]));
      run_len(1'b0, n);
      run_len(1'b0, n);
      chk(32'(n), 32'(10 / rates[i]), "internal half period");
    end
    av_req(1'b0, `MCCS_OFS_RATE, 32'h0);
    av_req(1'b0, `MCCS_OFS_RATE, 32'hb);
    av_rd(`MCCS_OFS_RATE, 32'ha, 32'hf);
    av_req(1'b0, `MCCS_OFS_RATE, 32'h2);
    $display("test rate done");
    for (int i = 0; i < 4; i++) begin
      d = (i == 3) ? 32'((($urandom % 511) + 1) * 2) : 32'h0;
      d = (i == 0) ? 32'h1 : (i == 1) ? 32'h2 : (i == 2) ? 32'h3fe : d;
      av_req(1'b0, `MCCS_OFS_DIV, d);
      av_rd(`MCCS_OFS_DIV, d, 32'h3ff);
    end
    av_req(1'b0, `MCCS_OFS_DIV, 32'h3);
    av_req(1'b0, `MCCS_OFS_DIV, 32'h3ff);
    av_req(1'b0, `MCCS_OFS_DIV, 32'h0);
    av_rd(`MCCS_OFS_DIV, d, 32'h3ff);
    av_rd(`MCCS_OFS_STAT, 32'h50, 32'h50);
    av_req(1'b0, `MCCS_OFS_STAT, 32'h50);
    av_rd(`MCCS_OFS_STAT, 32'h0, 32'h50);
    $display("test divider done");
    av_req(1'b0, `MCCS_OFS_DIV, 32'h2);
    av_req(1'b0, `MCCS_OFS_CMD, 32'h1);
    repeat (60) @(posedge clk_sys);
    av_rd(`MCCS_OFS_STAT, 32'h1, 32'hf);
    av_req(1'b0, `MCCS_OFS_CTRL, 32'h1);
    av_rd(`MCCS_OFS_STAT, 32'h1, 32'hf);
    av_req(1'b0, `MCCS_OFS_CMD, 32'h1);
    // Any run under five cycles during the handover is a runt
    for (int i = 0; i < 6; i++) begin
      run_len(1'b0, n);
      chk({31'h0, n >= 5}, 32'h1, "runt on switch");
    end
    run_len(1'b0, n);
    chk(32'(n), 32'd10, "divided half period");
    av_rd(`MCCS_OFS_STAT, 32'h4, 32'h7);
    chk({31'h0, gclk}, 32'h0, "global clock in config");
    $display("test switch done");
    rstn <= 1'b0;
    osc_half <= 16'd350;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    av_req(1'b0, `MCCS_OFS_CTRL, 32'h1);
    av_req(1'b0, `MCCS_OFS_CMD, 32'h1);
    repeat (4) run_len(1'b0, n);
    chk(32'(n), 32'd7, "undivided half period");
    av_req(1'b0, `MCCS_OFS_CTRL, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, cfg_pin.oe}, 32'h0, "pin released");
    run_len(1'b1, n);
    run_len(1'b1, n);
    chk(32'(n), 32'd7, "global clock run");
    chk({31'h0, user_io}, 32'h0, "standard before eos");
    av_req(1'b0, `MCCS_OFS_CTRL, 32'h7);
    repeat (2) @(posedge clk_sys);
    chk({31'h0, user_io}, 32'h1, "standard after eos");
    av_req(1'b0, `MCCS_OFS_CTRL, 32'h1b);
    repeat (2) @(posedge clk_sys);
    chk({30'h0, cfg_pin.oe, cfg_pin.out}, 32'h3, "user pin");
    $display("test release done");
    wrap_up();
  end
endmodule : mccs_clock_switch_bench
